// ---- core/pca_params.svh ----
// Offsets, field positions, reset values and limits of the proximity calibration block
`ifndef PCA_PARAMS_SVH
`define PCA_PARAMS_SVH
// ==========================================================
// Register offsets
`define PCA_ADDR_CAL_CFG 8'hD9
`define PCA_ADDR_CAL_STAT 8'hDC
`define PCA_ADDR_INT_EN 8'hDD
`define PCA_ADDR_FAC_LO 8'hE6
`define PCA_ADDR_FAC_HI 8'hE7
`define PCA_ADDR_TEST 8'hF9
// ==========================================================
// Reset values
`define PCA_RST_CAL_CFG 8'h50
`define PCA_RST_INT_EN 8'h00
`define PCA_RST_TEST 8'h0C
// ==========================================================
// Field positions
`define PCA_CFG_TGT_HI 7
`define PCA_CFG_TGT_LO 5
`define PCA_CFG_AUTO_BIT 3
`define PCA_CFG_AVG_HI 2
`define PCA_CFG_AVG_LO 0
`define PCA_STAT_ADJ_BIT 2
`define PCA_EN_KEEP_MASK 8'hFC
// ==========================================================
// Limits and search constants
`define PCA_AVG_MAX_CODE 3'h4
`define PCA_AUTO_LIMIT 3
`define PCA_OFS_BIAS 9'h100
`define PCA_SAR_TOP 4'h8
`endif

// ---- core/pca_pkg.sv ----
// Types shared by the proximity calibration block
package pca_pkg;
  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_PULSE = 5'b00010,
    S_CONV  = 5'b00100,
    S_AVG   = 5'b01000,
    S_STORE = 5'b10000
  } pca_state_t;
  // Byte register request from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pca_reg_req_t;
  // Interrupt sources held in the main status register
  typedef struct packed {
    logic light_sat;
    logic near_sat;
    logic near_thr;
    logic light_thr;
    logic zero_det;
  } pca_src_flags_t;
endpackage

// ---- core/pca_avg.sv ----
// Power-of-two sample averager for proximity conversions
`timescale 1ns/1ps
`include "pca_params.svh"
module pca_avg #(
  parameter int RES_W = 10
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clr_in,
  input wire logic smp_valid_in,
  input wire logic [RES_W-1:0] smp_data_in,
  input wire logic [2:0] avg_code_in,
  output logic avg_valid_out,
  output logic [RES_W-1:0] avg_data_out
);
  // ==========================================================
  // Result width must match the sequencer it serves
  if (RES_W < 9 || RES_W > 16) begin : g_bad_width
    $error("pca_avg: RES_W must lie in 9..16");
  end
  // Set size decode
  logic [RES_W+3:0] acc_reg; // Running sum, room for 16 samples
  logic [4:0] cnt_reg; // Samples taken in this set
  logic [2:0] shift_w; // Divide as a right shift
  logic [4:0] total_w; // Samples per set
  logic [RES_W+3:0] sum_w; // Sum including this sample
  logic last_w; // This sample closes the set
  // Reserved codes fall back to single samples rather than guess a size
  assign shift_w = (avg_code_in <= `PCA_AVG_MAX_CODE) ? avg_code_in : 3'h0; // [R6]
  assign total_w = 5'h01 << shift_w; // [R20]
  assign sum_w = acc_reg + {4'h0, smp_data_in}; // [R20]
  assign last_w = (cnt_reg + 5'h01) == total_w;
  // ==========================================================
  // Accumulate and divide
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_reg <= '0;
      cnt_reg <= 5'h00;
      avg_valid_out <= 1'b0;
      avg_data_out <= '0;
    end else begin
      avg_valid_out <= 1'b0;
      if (clr_in) begin
        // Drop a partial set when a new measurement begins
        acc_reg <= '0;
        cnt_reg <= 5'h00;
      end else if (smp_valid_in) begin
        if (last_w) begin
          avg_data_out <= RES_W'(sum_w >> shift_w); // [R20]
          avg_valid_out <= 1'b1;
          acc_reg <= '0;
          cnt_reg <= 5'h00;
        end else begin
          acc_reg <= sum_w;
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end
endmodule

// ---- core/pca_top.sv ----
// Proximity calibration, averaging, auto offset and interrupt enable logic
//
// Functional notes
// [R1]: Target code 0..7 gives 3..511; reset 2.
// [R2]: Calibration aims result at selected target baseline.
// [R3]: Auto adjust decrements offset on low result.
// [R4]: Each auto decrement sets the adjusted flag.
// [R5]: Flag clears on write-one or enable off.
// [R6]: Average code 0 off, 1..4 give 2..16.
// [R7]: Every sample emits full programmed pulse count.
// [R8]: Finished average goes straight to result.
// [R9]: Status bit 0 mirrors calibration interrupt flag.
// [R10]: Enables 7,6 gate light/near saturation.
// [R11]: Enables 5,4 gate near/light threshold.
// [R12]: Enables 3,2 calibration/zero; 1:0 read zero.
// [R13]: Host keeps config bit 4 at one.
// [R14]: Host writes 0x06 to test register.
// [R15]: Factory registers are read-only bytes.
// [R16]: Calibration searches signed offset toward target.
// [R17]: Completion loads offset, raises calibration flag.
// [R18]: Offset is sign plus eight-bit magnitude.
// [R19]: Interrupt output while enabled flag set.
// [R20]: Average by power-of-two sum and shift.
`timescale 1ns/1ps
`include "pca_params.svh"
module pca_top #(
  parameter int RES_W = 10,
  parameter logic [7:0] FACTORY_LOW = 8'h00, // Arbitrary value
  parameter logic [7:0] FACTORY_HIGH = 8'h00 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire pca_pkg::pca_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic measure_start_in,
  input wire logic cal_start_in,
  input wire logic [5:0] pulse_count_in,
  output logic emitter_pulse_out,
  output logic adc_start_out,
  input wire logic adc_done_in,
  input wire logic [RES_W-1:0] adc_data_in,
  input wire pca_pkg::pca_src_flags_t src_flags_in,
  input wire logic cal_flag_clear_in,
  output logic [RES_W-1:0] near_result_out,
  output logic result_valid_out,
  output logic [7:0] near_offset_magnitude_out,
  output logic near_offset_sign_out,
  output logic calibration_irq_flag_out,
  output logic irq_out,
  output logic busy_out
);
  // ==========================================================
  // Elaboration checks
  if (RES_W < 9 || RES_W > 16) begin : g_bad_width
    $error("pca_top: RES_W must lie in 9..16");
  end

  // ==========================================================
  // Reset release
  logic rst_meta_reg; // First stage, read only by the second
  logic rst_b; // Synchronised reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Register storage
  logic [7:0] cfg_reg; // Calibration configuration
  logic [7:0] int_en_reg; // Interrupt enables
  logic [7:0] test_reg; // Test trim byte
  logic adj_flag_reg; // Offset decremented flag
  logic cal_flag_reg; // Calibration interrupt flag
  logic [2:0] calib_target_sel; // Target code
  logic auto_offset_decrement_en; // Auto adjust enable
  logic [2:0] sample_average_count; // Averaging code
  assign calib_target_sel = cfg_reg[`PCA_CFG_TGT_HI:`PCA_CFG_TGT_LO];
  assign auto_offset_decrement_en = cfg_reg[`PCA_CFG_AUTO_BIT];
  assign sample_average_count = cfg_reg[`PCA_CFG_AVG_HI:`PCA_CFG_AVG_LO];

  // Address decode
  logic hit_cfg, hit_stat, hit_en, hit_fl, hit_fh, hit_test;
  assign hit_cfg = reg_req_in.addr == `PCA_ADDR_CAL_CFG;
  assign hit_stat = reg_req_in.addr == `PCA_ADDR_CAL_STAT;
  assign hit_en = reg_req_in.addr == `PCA_ADDR_INT_EN;
  assign hit_fl = reg_req_in.addr == `PCA_ADDR_FAC_LO;
  assign hit_fh = reg_req_in.addr == `PCA_ADDR_FAC_HI;
  assign hit_test = reg_req_in.addr == `PCA_ADDR_TEST;

  // Status byte: bit 2 adjusted flag, bit 0 calibration mirror
  logic [7:0] stat_w;
  assign stat_w = {5'h00, adj_flag_reg, 1'b0, cal_flag_reg}; // [R9]

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux = hit_cfg ? cfg_reg :
                  hit_stat ? stat_w :
                  hit_en ? int_en_reg :
                  hit_fl ? FACTORY_LOW : // [R15]
                  hit_fh ? FACTORY_HIGH : // [R15]
                  hit_test ? test_reg : 8'h00;

  // Host writes; factory bytes have no write path
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= `PCA_RST_CAL_CFG; // [R1]
      int_en_reg <= `PCA_RST_INT_EN; // [R10] [R11]
      test_reg <= `PCA_RST_TEST;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_req_in.wr && hit_cfg) begin
        cfg_reg <= reg_req_in.wdata;
      end
      if (reg_req_in.wr && hit_en) begin
        int_en_reg <= reg_req_in.wdata & `PCA_EN_KEEP_MASK; // [R12]
      end
      if (reg_req_in.wr && hit_test) begin
        test_reg <= reg_req_in.wdata;
      end
      if (reg_req_in.rd) begin
        reg_rdata_out <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Sequencer and datapath
  pca_pkg::pca_state_t state_reg;
  logic cal_active_reg; // Measurement belongs to calibration
  logic [8:0] trial_reg; // Biased trial offset, 256 means zero
  logic [3:0] bit_idx_reg; // Bit under test in the search
  logic [5:0] pulse_cnt_reg; // Pulses sent for this sample
  logic [7:0] ofs_mag_reg; // Stored offset magnitude
  logic ofs_sign_reg; // Stored offset sign
  logic avg_valid; // Averager set finished
  logic [RES_W-1:0] avg_data; // Averager output

  // Biased value to sign/magnitude; -256 clips to -255
  function automatic logic [8:0] to_sm(input logic [8:0] b);
    logic [8:0] neg;
    neg = `PCA_OFS_BIAS - b;
    if (b[8]) begin
      to_sm = {1'b0, b[7:0]};
    end else if (b == 9'h000) begin
      to_sm = 9'h1FF;
    end else begin
      to_sm = {1'b1, neg[7:0]};
    end
  endfunction

  // Offset in use: trial during calibration, else stored
  logic [8:0] trial_sm;
  logic use_sign;
  logic [7:0] use_mag;
  assign trial_sm = to_sm(trial_reg); // [R18]
  assign use_sign = cal_active_reg ? trial_sm[8] : ofs_sign_reg;
  assign use_mag = cal_active_reg ? trial_sm[7:0] : ofs_mag_reg;

  // Offset applied to the raw sample, clamped to the result range
  logic signed [RES_W+1:0] ofs_s, sum_s;
  logic [RES_W-1:0] corr_w;
  assign ofs_s = use_sign ? -$signed({{(RES_W-6){1'b0}}, use_mag}) :
                 $signed({{(RES_W-6){1'b0}}, use_mag}); // [R18]
  assign sum_s = $signed({2'b00, adc_data_in}) + ofs_s;
  assign corr_w = sum_s[RES_W+1] ? '0 : sum_s[RES_W] ? '1 : sum_s[RES_W-1:0];

  // Target 2^(code+2)-1 as the no-object baseline
  logic [RES_W-1:0] cal_target;
  assign cal_target = RES_W'((16'h0004 << calib_target_sel) - 16'h0001); // [R1] [R2]

  // Successive approximation step
  logic [8:0] kept_w, next_trial_w, bit_mask_w;
  assign bit_mask_w = 9'h001 << bit_idx_reg;
  // Keep the bit only while the result stays at or below target
  assign kept_w = (avg_data > cal_target) ? (trial_reg & ~bit_mask_w) : trial_reg; // [R16]
  assign next_trial_w = kept_w | (bit_mask_w >> 1);
  logic [8:0] final_sm;
  assign final_sm = to_sm(kept_w);

  // Auto decrement: one count lower in signed terms
  logic dec_evt;
  logic [7:0] dec_mag;
  logic dec_sign;
  assign dec_evt = state_reg == pca_pkg::S_STORE && !cal_active_reg &&
                   auto_offset_decrement_en &&
                   avg_data < RES_W'(`PCA_AUTO_LIMIT); // [R3]
  // Saturate at -255 so the magnitude never wraps
  assign dec_sign = ofs_sign_reg | (ofs_mag_reg == 8'h00);
  assign dec_mag = !dec_sign ? ofs_mag_reg - 8'h01 :
                   (ofs_mag_reg == 8'hFF) ? 8'hFF : ofs_mag_reg + 8'h01;

  logic cal_finish;
  assign cal_finish = state_reg == pca_pkg::S_STORE && cal_active_reg &&
                      bit_idx_reg == 4'h0;

  pca_avg #(.RES_W(RES_W)) u_avg (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .clr_in(state_reg == pca_pkg::S_IDLE),
    .smp_valid_in(state_reg == pca_pkg::S_CONV && adc_done_in),
    .smp_data_in(corr_w),
    .avg_code_in(sample_average_count), // [R6]
    .avg_valid_out(avg_valid),
    .avg_data_out(avg_data)
  );

  // Main sequencer
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= pca_pkg::S_IDLE;
      cal_active_reg <= 1'b0;
      trial_reg <= `PCA_OFS_BIAS;
      bit_idx_reg <= `PCA_SAR_TOP;
      pulse_cnt_reg <= 6'h00;
      emitter_pulse_out <= 1'b0;
      adc_start_out <= 1'b0;
      near_result_out <= '0;
      result_valid_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      adc_start_out <= 1'b0;
      result_valid_out <= 1'b0;
      emitter_pulse_out <= 1'b0;
      case (state_reg)
        pca_pkg::S_IDLE: begin
          // Calibration wins over a plain measurement
          if (cal_start_in) begin
            cal_active_reg <= 1'b1;
            trial_reg <= `PCA_OFS_BIAS;
            bit_idx_reg <= `PCA_SAR_TOP;
            state_reg <= pca_pkg::S_PULSE;
            busy_out <= 1'b1;
          end else if (measure_start_in) begin
            state_reg <= pca_pkg::S_PULSE;
            busy_out <= 1'b1;
          end
        end
        pca_pkg::S_PULSE: begin
          // High one cycle, low one cycle, per pulse
          if (!emitter_pulse_out) begin
            emitter_pulse_out <= 1'b1; // [R7]
          end else if (pulse_cnt_reg == pulse_count_in) begin
            pulse_cnt_reg <= 6'h00;
            adc_start_out <= 1'b1; // [R7]
            state_reg <= pca_pkg::S_CONV;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 6'h01;
          end
        end
        pca_pkg::S_CONV: begin
          if (adc_done_in) begin
            state_reg <= pca_pkg::S_AVG;
          end
        end
        pca_pkg::S_AVG: begin
          // Another sample unless the set just closed
          state_reg <= avg_valid ? pca_pkg::S_STORE : pca_pkg::S_PULSE;
        end
        pca_pkg::S_STORE: begin
          if (!cal_active_reg) begin
            near_result_out <= avg_data; // [R8]
            result_valid_out <= 1'b1;
            state_reg <= pca_pkg::S_IDLE;
            busy_out <= 1'b0;
          end else if (cal_finish) begin
            cal_active_reg <= 1'b0; // [R17]
            state_reg <= pca_pkg::S_IDLE;
            busy_out <= 1'b0;
          end else begin
            trial_reg <= next_trial_w; // [R16]
            bit_idx_reg <= bit_idx_reg - 4'h1;
            state_reg <= pca_pkg::S_PULSE;
          end
        end
        default: begin
          state_reg <= pca_pkg::S_IDLE;
          cal_active_reg <= 1'b0;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Offset, flags and interrupt
  logic adj_w1c; // Host writes one to the adjusted bit
  assign adj_w1c = reg_req_in.wr && hit_stat && reg_req_in.wdata[`PCA_STAT_ADJ_BIT];
  logic [7:0] irq_vec;
  assign irq_vec = {src_flags_in.light_sat, src_flags_in.near_sat, // [R10]
                    src_flags_in.near_thr, src_flags_in.light_thr, // [R11]
                    cal_flag_reg, src_flags_in.zero_det, 2'b00} & int_en_reg; // [R12]

  // Events win over clears in the same cycle
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ofs_mag_reg <= 8'h00;
      ofs_sign_reg <= 1'b0;
      adj_flag_reg <= 1'b0;
      cal_flag_reg <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (cal_finish) begin
        ofs_sign_reg <= final_sm[8]; // [R17]
        ofs_mag_reg <= final_sm[7:0];
      end else if (dec_evt) begin
        ofs_sign_reg <= dec_sign; // [R3]
        ofs_mag_reg <= dec_mag;
      end
      adj_flag_reg <= dec_evt | (adj_flag_reg && !adj_w1c && auto_offset_decrement_en); // [R4] [R5]
      cal_flag_reg <= cal_finish | (cal_flag_reg && !cal_flag_clear_in); // [R17] [R9]
      irq_out <= |irq_vec; // [R19]
    end
  end
  assign near_offset_magnitude_out = ofs_mag_reg;
  assign near_offset_sign_out = ofs_sign_reg;
  assign calibration_irq_flag_out = cal_flag_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b);
  logic [6:0] hp_cnt_reg; // Pulses seen since the last conversion start
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      hp_cnt_reg <= 7'h00;
    end else begin
      hp_cnt_reg <= adc_start_out ? 7'h00 : hp_cnt_reg + {6'h00, emitter_pulse_out};
    end
  end
  sequence s_cal_end;
    cal_finish ##1 !busy_out;
  endsequence
  a_pulse_count: assert property (adc_start_out |-> hp_cnt_reg == {1'b0, pulse_count_in} + 7'h01) // [R7]
    else $error("Pulse count per sample wrong");
  a_flag_sets: assert property (dec_evt |=> adj_flag_reg && stat_w[2]) // [R4]
    else $error("Adjusted flag not set");
  a_flag_clear: assert property (!auto_offset_decrement_en |=> !adj_flag_reg) // [R5]
    else $error("Adjusted flag kept with enable off");
  a_mirror_read: assert property (reg_req_in.rd && hit_stat |=> reg_rdata_out[0] == $past(cal_flag_reg)) // [R9]
    else $error("Status mirror mismatch");
  a_cal_load: assert property (s_cal_end |-> cal_flag_reg && {ofs_sign_reg, ofs_mag_reg} == $past(final_sm)) // [R17]
    else $error("Calibration result not loaded");
  a_irq_gate: assert property (irq_out == $past(|irq_vec)) // [R19]
    else $error("Interrupt output not gated by enables");
  a_en_reserved: assert property (reg_req_in.rd && hit_en |=> reg_rdata_out[1:0] == 2'b00) // [R12]
    else $error("Reserved enable bits not zero");
  a_result_write: assert property (state_reg == pca_pkg::S_STORE && !cal_active_reg |=> result_valid_out && near_result_out == $past(avg_data)) // [R8]
    else $error("Average not written to result");
  a_offset_form: assert property (ofs_sign_reg |-> ofs_mag_reg != 8'h00) // [R18]
    else $error("Negative zero offset");
endmodule

// ---- sim/pca_adc_model.sv ----
// Behavioural front end that answers each conversion request of the block
`timescale 1ns/1ps
module pca_adc_model (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [9:0] level_in,
  input wire logic [3:0] wait_in,
  output logic done_out,
  output logic [9:0] data_out
);
  // ==========================================
  // Conversion timer
  logic [9:0] held_reg; // Level latched at the request
  logic [4:0] cnt_reg; // Cycles left before the answer
  logic busy_reg; // Conversion in flight
  initial begin
    held_reg = 10'h155;
    cnt_reg = 5'h00;
    busy_reg = 1'b0;
    done_out = 1'b0;
    data_out = 10'h2AA;
  end
  // Latch on request, answer after a wait the bench chooses
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    // Data is only good with done, so the idle bus shows the inverse
    data_out <= ~held_reg;
    if (start_in) begin
      held_reg <= level_in;
      cnt_reg <= {1'b0, wait_in};
      busy_reg <= 1'b1;
    end else if (busy_reg && cnt_reg == 5'h00) begin
      done_out <= 1'b1;
      data_out <= held_reg;
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the proximity calibration block
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // Stimulus and observed signals
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  pca_pkg::pca_reg_req_t reg_req_in = '0;
  logic measure_start_in = 1'b0;
  logic cal_start_in = 1'b0;
  logic [5:0] pulse_count_in = 6'h00;
  pca_pkg::pca_src_flags_t src_flags_in = '0;
  logic cal_flag_clear_in = 1'b0;
  logic [9:0] level = 10'h000; // Front end input level
  logic [3:0] adc_wait = 4'h0; // Front end answer delay
  logic [7:0] reg_rdata_out, near_offset_magnitude_out;
  logic [9:0] near_result_out, adc_data_in;
  logic emitter_pulse_out, adc_start_out, adc_done_in, result_valid_out;
  logic near_offset_sign_out, calibration_irq_flag_out, irq_out, busy_out;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] rnd = 16'h2041; // Fixed seed keeps runs repeatable
  // ==========================================
  // Design and front end
  // Factory bytes are arbitrary
  pca_top #(.RES_W(10), .FACTORY_LOW(8'h3C), .FACTORY_HIGH(8'hC3)) pca_top_i (
    .clk_in, .rst_b_in, .reg_req_in, .reg_rdata_out, .measure_start_in, .cal_start_in,
    .pulse_count_in, .emitter_pulse_out, .adc_start_out, .adc_done_in, .adc_data_in,
    .src_flags_in, .cal_flag_clear_in, .near_result_out, .result_valid_out,
    .near_offset_magnitude_out, .near_offset_sign_out, .calibration_irq_flag_out,
    .irq_out, .busy_out);
  pca_adc_model pca_adc_model_i (.clk_in, .start_in(adc_start_out), .level_in(level),
    .wait_in(adc_wait), .done_out(adc_done_in), .data_out(adc_data_in));
  // 50 ns period
  always #25 clk_in = ~clk_in;
  // ==========================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Offset the search should settle on, -256 clips to -255
  function automatic int cal_off(input int v, input int code);
    int o;
    o = (1 << (code + 2)) - 1 - v + 256;
    o = (o > 511) ? 511 : ((o < 0) ? 0 : o);
    return (o < 1) ? -255 : o - 256;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_req_in <= '{1'b1, 1'b0, a, d};
    @(negedge clk_in);
    reg_req_in <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    @(negedge clk_in);
    reg_req_in <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    reg_req_in <= '0;
    chk(what, 16'(reg_rdata_out), 16'(e));
  endtask
  // One measurement or calibration; a negative level draws fresh samples
  task automatic run(input logic cal, input int fixv, output int pulses, output int starts,
                     output int sum, output logic [9:0] res);
    logic idle;
    pulses = 0;
    starts = 0;
    sum = 0;
    idle = 1'b0;
    res = 'x;
    @(negedge clk_in);
    if (cal) cal_start_in <= 1'b1;
    else measure_start_in <= 1'b1;
    for (int i = 0; i < 9000; i++) begin
      @(negedge clk_in);
      cal_start_in <= 1'b0;
      measure_start_in <= 1'b0;
      pulses += int'(emitter_pulse_out);
      // Set the level the front end latches on the next edge
      if (adc_start_out) begin
        rnd = lfsr(rnd);
        level <= (fixv >= 0) ? 10'(fixv) : rnd[9:0];
        adc_wait <= rnd[13:10];
        sum += (fixv >= 0) ? fixv : int'(rnd[9:0]);
        starts++;
      end
      if (result_valid_out) res = near_result_out;
      if (!busy_out && idle) return;
      idle = !busy_out;
    end
    chk("busy_out", 16'(busy_out), 16'h0000);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(negedge clk_in);
    num_errors++;
    give_verdict();
  end
  // ==========================================
  // Main sequence
  initial begin
    int p, s, sum, v, code, off;
    logic [9:0] res;
    logic [7:0] m;
    repeat (3) @(negedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    // Reset values, read-only and unmapped places
    rd_chk(8'hD9, 8'h50, "config reset");
    rd_chk(8'hDD, 8'h00, "enables reset");
    rd_chk(8'hDC, 8'h00, "status reset");
    rd_chk(8'hF9, 8'h0C, "test reset");
    wr(8'hF9, 8'h06);
    rd_chk(8'hF9, 8'h06, "test write");
    wr(8'hE6, 8'hFF);
    wr(8'hE7, 8'h00);
    rd_chk(8'hE6, 8'h3C, "factory low");
    rd_chk(8'hE7, 8'hC3, "factory high");
    rd_chk(8'h10, 8'h00, "unmapped");
    $display("registers test done");
    // Enable readback, then each source alone through its enable
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(8'hDD, rnd[7:0]);
      rd_chk(8'hDD, rnd[7:0] & 8'hFC, "enables");
    end
    for (int k = 0; k < 5; k++) begin
      m = (k == 0) ? 8'h04 : (8'h08 << k);
      wr(8'hDD, 8'hFC & ~m);
      src_flags_in <= 5'(1 << k);
      repeat (3) @(negedge clk_in);
      chk("irq masked", 16'(irq_out), 16'h0000);
      wr(8'hDD, m);
      repeat (2) @(negedge clk_in);
      chk("irq enabled", 16'(irq_out), 16'h0001);
      src_flags_in <= '0;
    end
    wr(8'hDD, 8'h00);
    $display("interrupt enable test done");
    // Every averaging code, reserved code 5 acting as one sample
    for (code = 0; code < 6; code++) begin
      rnd = lfsr(rnd);
      pulse_count_in <= 6'(rnd[1:0]);
      wr(8'hD9, {3'h2, 1'b1, 1'b0, 3'(code)});
      run(1'b0, -1, p, s, sum, res);
      chk("samples", 16'(s), 16'((code > 4) ? 1 : (1 << code)));
      chk("pulses", 16'(p), 16'(s * (int'(pulse_count_in) + 1)));
      chk("average", 16'(res), 16'(sum >> ((code > 4) ? 0 : code)));
    end
    $display("averaging test done");
    // Low results walk the offset down and raise the sticky flag
    wr(8'hD9, 8'h58);
    run(1'b0, 1, p, s, sum, res);
    run(1'b0, 1, p, s, sum, res);
    chk("offset", 16'({near_offset_sign_out, near_offset_magnitude_out}), 16'h0102);
    rd_chk(8'hDC, 8'h04, "adjusted set");
    wr(8'hDC, 8'h04);
    rd_chk(8'hDC, 8'h00, "adjusted write clear");
    run(1'b0, 1, p, s, sum, res);
    rd_chk(8'hDC, 8'h04, "adjusted again");
    wr(8'hD9, 8'h50);
    rd_chk(8'hDC, 8'h00, "adjusted disable clear");
    $display("auto offset test done");
    // Calibration toward top and random targets, then the baseline
    for (int j = 0; j < 3; j++) begin
      rnd = lfsr(rnd);
      code = (j == 0) ? 7 : int'(rnd[2:0]);
      v = 100 + int'(rnd[12:5]);
      off = cal_off(v, code);
      wr(8'hD9, {3'(code), 5'h10});
      wr(8'hDD, 8'h08);
      run(1'b1, v, p, s, sum, res);
      chk("rounds", 16'(s), 16'h0009);
      chk("cal offset", 16'({near_offset_sign_out, near_offset_magnitude_out}),
          16'((off < 0) ? 256 - off : off));
      chk("cal flag", 16'(calibration_irq_flag_out), 16'h0001);
      chk("irq cal", 16'(irq_out), 16'h0001);
      rd_chk(8'hDC, 8'h01, "done mirror");
      @(negedge clk_in);
      cal_flag_clear_in <= 1'b1;
      @(negedge clk_in);
      cal_flag_clear_in <= 1'b0;
      rd_chk(8'hDC, 8'h00, "mirror clear");
      chk("irq cal clear", 16'(irq_out), 16'h0000);
      run(1'b0, v, p, s, sum, res);
      chk("baseline", 16'(res), 16'((v + off < 0) ? 0 : v + off));
    end
    $display("calibration test done");
    give_verdict();
  end
endmodule
